// *** rtl/cte_consts.svh ***
// Purpose: Constants for the transfer and arithmetic execution core.
// Assumes: Memory answers a read strobe with data on the following cycle.
// Notes: State counts are whole instruction lengths in sys_clk cycles.
// Behaviour
// - Data transfer instructions never change any condition flag.
// - Register copy moves source into destination register, five states.
// - Memory copy forms use the byte addressed by H (high) and L.
// - Memory immediate load writes byte two to H,L address, ten states.
// - Pair immediate load: byte three to high register, byte two low.
// - Direct accumulator load/store uses address byte3:byte2, thirteen states.
// - Direct HL load: L from address, H from address plus one.
// - Direct HL store: L to address, H to next address, sixteen states.
// - Indirect accumulator load/store address through B,C or D,E only, seven states.
// - Pair swap exchanges H with D and L with E, no flags.
// - Memory decrement writes back byte minus one, all flags but carry.
// - Pair increment adds one across both registers, no flag change.
// - Arithmetic instructions update zero, sign, parity, carry and half carry.
// - Subtraction is two's complement; carry flag means borrow.
// - Register add puts accumulator plus register into accumulator.
// - Memory add uses the H,L addressed byte, seven states.
// - Immediate add uses byte two, seven states, all five flags.
// - Add with carry also adds the current carry flag.
// - Subtract forms put accumulator minus operand into accumulator.
// - Subtract with borrow also subtracts the current carry flag.
// - Register field: 111 A, 000 B, 001 C, 010 D, 011 E, 100 H, 101 L.
// - Pair field: 00 B,C, 01 D,E, 10 H,L, 11 stack pointer.
// - Zero on zero result, sign from bit 7, parity set when even.
// - Half carry set on carry out of bit 3 into bit 4.
`ifndef CTE_CONSTS_SVH
`define CTE_CONSTS_SVH

// ==========================================================================
// Register indices and fields.
`define CTE_IX_B 3'h0
`define CTE_IX_C 3'h1
`define CTE_IX_D 3'h2
`define CTE_IX_E 3'h3
`define CTE_IX_H 3'h4
`define CTE_IX_L 3'h5
`define CTE_FLD_MEM 3'h6
`define CTE_IX_A 3'h7
`define CTE_RP_SP 2'h3

// ==========================================================================
// Flag positions on the flag output.
`define CTE_FLG_CY 0
`define CTE_FLG_P 1
`define CTE_FLG_AC 2
`define CTE_FLG_Z 3
`define CTE_FLG_S 4

// ==========================================================================
// Fixed opcodes.
`define CTE_OP_HALT 8'h76
`define CTE_OP_STORE_PAIR_HL_DIRECT 8'h22
`define CTE_OP_LOAD_PAIR_HL_DIRECT 8'h2A
`define CTE_OP_STA 8'h32
`define CTE_OP_LDA 8'h3A
`define CTE_OP_SWAP_PAIRS 8'hEB

// ==========================================================================
// Instruction lengths in states.
`define CTE_T_4 5'h04
`define CTE_T_5 5'h05
`define CTE_T_7 5'h07
`define CTE_T_10 5'h0A
`define CTE_T_13 5'h0D
`define CTE_T_16 5'h10

// ==========================================================================
// Reset values.
`define CTE_PC_RST 16'h0000
`define CTE_SP_RST 16'h0000
`define CTE_REG_RST 8'h00

`endif

// *** rtl/cte_pkg.sv ***
// Purpose: Types for the transfer and arithmetic execution core.
// Assumes: Nothing beyond the constants header.
// Notes: Sequencer states are one-hot.
package cte_pkg;

  // ========================================================================
  // Sequencer states.
  typedef enum logic [4:0] {
    CTE_ST_ISSUE = 5'h01,
    CTE_ST_STROBE = 5'h02,
    CTE_ST_CAPT = 5'h04,
    CTE_ST_WRITE = 5'h08,
    CTE_ST_WAIT = 5'h10
  } cte_state_t;

endpackage : cte_pkg

// *** rtl/cte_core.sv ***
// Purpose: Fetch, decode and execute transfer and arithmetic instructions.
// Assumes: Synchronous byte memory on sys_clk, data valid the cycle after mem_rd.
// Notes: Unsupported opcodes are skipped in four states and flagged.
`timescale 1ns/1ps
`default_nettype none
`include "cte_consts.svh"

module cte_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Memory bus
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Status
  output logic [7:0] acc_out,
  output logic [4:0] flags_out,
  output logic [15:0] pc_out,
  output logic instr_done,
  output logic bad_opcode
);

  // ========================================================================
  // State.
  cte_pkg::cte_state_t st_q;
  logic [7:0] regs_q [0:7];
  logic [7:0] regs_d [0:7];
  logic [7:0] op_q, b2_q, tmp_q, tmp_d;
  logic [2:0] step_q;
  logic [1:0] widx_q;
  logic [4:0] cnt_q;
  logic [15:0] pc_q, sp_q, sp_d, addr_q;
  logic rd_q, wr_q, done_q, bad_q;
  logic [7:0] wdata_q;
  logic z_q, s_q, p_q, cy_q, ac_q;

  // ========================================================================
  // Decode. The opcode is taken straight off the bus in its capture cycle.
  wire capt = st_q == cte_pkg::CTE_ST_CAPT;
  wire [7:0] op = (capt && step_q == 3'h0) ? mem_rdata : op_q;
  wire [2:0] dst = op[5:3];
  wire [2:0] src = op[2:0];
  wire [1:0] rp = op[5:4];
  wire grp0 = op[7:6] == 2'h0;
  wire m_src = src == `CTE_FLD_MEM;
  wire m_dst = dst == `CTE_FLD_MEM;
  wire is_mov = op[7:6] == 2'h1 && op != `CTE_OP_HALT;
  wire is_mvi = grp0 && src == 3'h6;
  wire is_lxi = grp0 && op[3:0] == 4'h1;
  wire is_store_acc_indirect = grp0 && !op[5] && op[3:0] == 4'h2;
  wire is_load_acc_indirect = grp0 && !op[5] && op[3:0] == 4'hA;
  wire is_inx = grp0 && op[3:0] == 4'h3;
  wire is_id = grp0 && (src == 3'h4 || src == 3'h5);
  wire is_store_pair_hl_direct = op == `CTE_OP_STORE_PAIR_HL_DIRECT;
  wire is_load_pair_hl_direct = op == `CTE_OP_LOAD_PAIR_HL_DIRECT;
  wire is_sta = op == `CTE_OP_STA;
  wire is_lda = op == `CTE_OP_LDA;
  wire is_swap_pairs = op == `CTE_OP_SWAP_PAIRS;
  wire is_alu = op[7:5] == 3'h4;
  wire is_alui = op[7:6] == 2'h3 && !op[5] && src == 3'h6;
  wire is_dir = is_lda | is_sta | is_load_pair_hl_direct | is_store_pair_hl_direct;
  wire is_ind = is_load_acc_indirect | is_store_acc_indirect;
  wire legal = is_mov | is_mvi | is_lxi | is_ind | is_inx | is_id | is_dir | is_swap_pairs
               | is_alu | is_alui;

  // ========================================================================
  // Sequencing counts.
  wire [2:0] n_bytes = (is_lxi | is_dir) ? 3'h3 : (is_mvi | is_alui) ? 3'h2 : 3'h1;
  wire [2:0] n_data = is_load_pair_hl_direct ? 3'h2 :
                      (is_lda | is_load_acc_indirect | ((is_mov | is_alu) & m_src) | (is_id & m_dst))
                      ? 3'h1 : 3'h0;
  wire [1:0] n_wr = is_store_pair_hl_direct ? 2'h2 :
                    (is_sta | is_store_acc_indirect | ((is_mov | is_mvi | is_id) & m_dst)) ? 2'h1 : 2'h0;
  wire [2:0] last_idx = 3'(n_bytes + n_data - 3'h1);
  wire last_rd = step_q == last_idx;
  wire [2:0] didx = 3'(step_q - n_bytes);
  wire fetch_pc = step_q == 3'h0 || step_q < n_bytes;
  wire [4:0] need = !legal ? `CTE_T_4 :
                    is_mov ? ((m_src | m_dst) ? `CTE_T_7 : `CTE_T_5) :
                    is_mvi ? (m_dst ? `CTE_T_10 : `CTE_T_7) :
                    is_lxi ? `CTE_T_10 :
                    (is_lda | is_sta) ? `CTE_T_13 :
                    (is_load_pair_hl_direct | is_store_pair_hl_direct) ? `CTE_T_16 :
                    is_ind ? `CTE_T_7 :
                    is_swap_pairs ? `CTE_T_4 :
                    is_id ? (m_dst ? `CTE_T_10 : `CTE_T_5) :
                    is_inx ? `CTE_T_5 :
                    is_alu ? (m_src ? `CTE_T_7 : `CTE_T_4) :
                    `CTE_T_7;

  // ========================================================================
  // Addresses and operands.
  wire [15:0] hl = {regs_q[`CTE_IX_H], regs_q[`CTE_IX_L]};
  wire [15:0] rp_val = (rp == `CTE_RP_SP) ? sp_q :
                       {regs_q[{rp, 1'b0}], regs_q[{rp, 1'b1}]};
  wire [15:0] mptr = is_dir ? {mem_rdata, b2_q} : is_ind ? rp_val : hl;
  logic [7:0] b3_q;
  wire [15:0] dptr = is_dir ? {b3_q, b2_q} : mptr;
  wire [15:0] rd_addr = fetch_pc ? pc_q : 16'(dptr + {13'h0000, didx});
  wire [15:0] wr_addr = 16'(dptr + {14'h0000, widx_q});
  wire [7:0] wr_data = is_store_pair_hl_direct ? (widx_q == 2'h0 ? regs_q[`CTE_IX_L] : regs_q[`CTE_IX_H])
                       : tmp_q;
  wire [7:0] byte2 = (step_q == 3'h1) ? mem_rdata : b2_q;
  wire [15:0] pair_inc = 16'(rp_val + 16'h0001);

  // ========================================================================
  // Adder shared by the arithmetic group and the increment and decrement forms.
  wire alu_sub = is_id ? src[0] : op[4];
  wire alu_usec = (is_alu | is_alui) & op[3];
  wire [7:0] alu_a = is_id ? (m_dst ? mem_rdata : regs_q[dst]) : regs_q[`CTE_IX_A];
  wire [7:0] alu_opnd = is_id ? 8'h01 : is_alui ? byte2 : m_src ? mem_rdata : regs_q[src];
  // Subtraction adds the complement with an inverted carry in and inverts the carry out,
  // so the carry flag reads as a borrow.
  wire [7:0] alu_b = alu_sub ? ~alu_opnd : alu_opnd;
  wire alu_ci = alu_sub ^ (alu_usec & cy_q);
  wire [8:0] alu_sum = 9'({1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_ci});
  wire [4:0] alu_lo = 5'({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_ci});
  wire [7:0] alu_res = alu_sum[7:0];
  wire alu_cy = alu_sum[8] ^ alu_sub;

  // ========================================================================
  // Execution strobes.
  wire exec = capt && last_rd;
  wire load_pair_hl_direct_lo = capt && is_load_pair_hl_direct && step_q == 3'h3;
  wire set_all = exec && (is_alu | is_alui);
  wire set_nocy = exec && is_id;
  assign tmp_d = is_id ? alu_res : is_mvi ? byte2 : is_mov ? regs_q[src]
                 : regs_q[`CTE_IX_A];

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      regs_d[i] = regs_q[i];
    end
    sp_d = sp_q;
    if (load_pair_hl_direct_lo) begin
      regs_d[`CTE_IX_L] = mem_rdata;
    end
    if (exec) begin
      if (is_mov && !m_dst) begin
        regs_d[dst] = m_src ? mem_rdata : regs_q[src];
      end else if (is_mvi && !m_dst) begin
        regs_d[dst] = byte2;
      end else if (is_lxi) begin
        if (rp == `CTE_RP_SP) begin
          sp_d = {mem_rdata, b2_q};
        end else begin
          regs_d[{rp, 1'b0}] = mem_rdata;
          regs_d[{rp, 1'b1}] = b2_q;
        end
      end else if (is_lda || is_load_acc_indirect) begin
        regs_d[`CTE_IX_A] = mem_rdata;
      end else if (is_load_pair_hl_direct) begin
        regs_d[`CTE_IX_H] = mem_rdata;
      end else if (is_swap_pairs) begin
        regs_d[`CTE_IX_H] = regs_q[`CTE_IX_D];
        regs_d[`CTE_IX_D] = regs_q[`CTE_IX_H];
        regs_d[`CTE_IX_L] = regs_q[`CTE_IX_E];
        regs_d[`CTE_IX_E] = regs_q[`CTE_IX_L];
      end else if (is_id && !m_dst) begin
        regs_d[dst] = alu_res;
      end else if (is_inx) begin
        if (rp == `CTE_RP_SP) begin
          sp_d = pair_inc;
        end else begin
          regs_d[{rp, 1'b0}] = pair_inc[15:8];
          regs_d[{rp, 1'b1}] = pair_inc[7:0];
        end
      end else if (is_alu || is_alui) begin
        regs_d[`CTE_IX_A] = alu_res;
      end
    end
  end

  // ========================================================================
  // Register file and flags. Flags move only on arithmetic and increment/decrement strobes.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= `CTE_REG_RST;
      end
      sp_q <= `CTE_SP_RST;
    end else begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= regs_d[i];
      end
      sp_q <= sp_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      {z_q, s_q, p_q, cy_q, ac_q} <= 5'h00;
    end else if (set_all || set_nocy) begin
      z_q <= alu_res == 8'h00;
      s_q <= alu_res[7];
      p_q <= ~^alu_res;
      ac_q <= alu_lo[4];
      cy_q <= set_all ? alu_cy : cy_q;
    end
  end

  // ========================================================================
  // Bus sequencer. A read takes issue, strobe and capture cycles; a write one cycle.
  // The wait state pads each instruction to its full state count.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q <= cte_pkg::CTE_ST_ISSUE;
      {op_q, b2_q, b3_q, tmp_q, wdata_q} <= 40'h00_0000_0000;
      {step_q, widx_q, cnt_q} <= 10'h000;
      pc_q <= `CTE_PC_RST;
      addr_q <= 16'h0000;
      {rd_q, wr_q, done_q, bad_q} <= 4'h0;
    end else begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      bad_q <= exec && !legal;
      cnt_q <= 5'(cnt_q + 5'h01);
      case (st_q)
        cte_pkg::CTE_ST_ISSUE: begin
          addr_q <= rd_addr;
          rd_q <= 1'b1;
          pc_q <= fetch_pc ? 16'(pc_q + 16'h0001) : pc_q;
          st_q <= cte_pkg::CTE_ST_STROBE;
        end
        cte_pkg::CTE_ST_STROBE: begin
          st_q <= cte_pkg::CTE_ST_CAPT;
        end
        cte_pkg::CTE_ST_CAPT: begin
          if (step_q == 3'h0) op_q <= mem_rdata;
          if (step_q == 3'h1) b2_q <= mem_rdata;
          if (step_q == 3'h2) b3_q <= mem_rdata;
          if (exec) tmp_q <= tmp_d;
          if (!last_rd) begin
            step_q <= 3'(step_q + 3'h1);
            st_q <= cte_pkg::CTE_ST_ISSUE;
          end else if (n_wr != 2'h0) begin
            st_q <= cte_pkg::CTE_ST_WRITE;
          end else begin
            st_q <= cte_pkg::CTE_ST_WAIT;
          end
        end
        cte_pkg::CTE_ST_WRITE: begin
          addr_q <= wr_addr;
          wdata_q <= wr_data;
          wr_q <= 1'b1;
          widx_q <= 2'(widx_q + 2'h1);
          if (2'(widx_q + 2'h1) == n_wr) st_q <= cte_pkg::CTE_ST_WAIT;
        end
        cte_pkg::CTE_ST_WAIT: begin
          if (cnt_q >= 5'(need - 5'h01)) begin
            done_q <= 1'b1;
            cnt_q <= 5'h00;
            step_q <= 3'h0;
            widx_q <= 2'h0;
            st_q <= cte_pkg::CTE_ST_ISSUE;
          end
        end
        default: begin
          st_q <= cte_pkg::CTE_ST_ISSUE;
        end
      endcase
    end
  end

  // ========================================================================
  // Outputs.
  assign mem_addr = addr_q;
  assign mem_rd = rd_q;
  assign mem_wr = wr_q;
  assign mem_wdata = wdata_q;
  assign acc_out = regs_q[`CTE_IX_A];
  assign pc_out = pc_q;
  assign instr_done = done_q;
  assign bad_opcode = bad_q;
  assign flags_out[`CTE_FLG_CY] = cy_q;
  assign flags_out[`CTE_FLG_P] = p_q;
  assign flags_out[`CTE_FLG_AC] = ac_q;
  assign flags_out[`CTE_FLG_Z] = z_q;
  assign flags_out[`CTE_FLG_S] = s_q;

endmodule : cte_core
`default_nettype wire

// *** sim/cte_core_props.sv ***
// Purpose: Port-level timing checks for the execution core.
// Assumes: Memory answers one cycle after a read strobe.
// Notes: Bound to every cte_core instance.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Checker.
module cte_core_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Memory bus
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Status
  input wire logic [7:0] acc_out,
  input wire logic [4:0] flags_out,
  input wire logic [15:0] pc_out,
  input wire logic instr_done,
  input wire logic bad_opcode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  read_spacing_a: assert property (mem_rd |=> !mem_rd [*2])
    else $error("read strobes closer than three cycles");
  bus_exclusive_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
  done_pulse_a: assert property (instr_done |=> !instr_done)
    else $error("instruction done held longer than one cycle");
  skip_no_effect_a: assert property (bad_opcode |=> instr_done && $stable(acc_out))
    else $error("unsupported opcode not skipped cleanly");
  wdata_hold_a: assert property (mem_wr |=> (mem_wr || $stable(mem_wdata)))
    else $error("write data did not hold after the strobe");
  pair_write_a: assert property (mem_wr && $past(mem_wr) |->
    mem_addr == $past(mem_addr) + 16'h0001) else $error("second pair byte not at next address");
  write_ends_a: assert property (mem_wr |-> ##[0:8] instr_done)
    else $error("write not followed by instruction end");
  read_ends_a: assert property (mem_rd |-> ##[1:16] instr_done)
    else $error("read not followed by instruction end");
  acc_timing_a: assert property ($changed(acc_out) |-> $past(instr_done) or ##[0:2] instr_done)
    else $error("accumulator changed away from instruction end");
  flag_timing_a: assert property ($changed(flags_out) |-> $past(instr_done) or ##[0:4] instr_done)
    else $error("flags changed away from instruction end");
endmodule : cte_core_props

bind cte_core cte_core_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .acc_out(acc_out), .flags_out(flags_out), .pc_out(pc_out),
  .instr_done(instr_done), .bad_opcode(bad_opcode));

`default_nettype wire

// *** sim/cte_mem_model.sv ***
// Purpose: Byte memory on the far side of the core.
// Assumes: Read data is handed over one cycle after the read strobe.
// Notes: Between reads the data lines toggle, so a sample one cycle late never looks valid.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Memory.
module cte_mem_model (
  // Clock
  input wire logic sys_clk,
  // Memory bus
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  initial mem_rdata = 8'h00;
  always @(posedge sys_clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) mem_rdata <= mem[mem_addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule : cte_mem_model

`default_nettype wire

// *** sim/cte_core_bench.sv ***
// Purpose: Self-checking run of the execution core against a byte memory.
// Assumes: The program is placed in memory before reset is released.
// Notes: Expected state is tracked by a reference model built with the program.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bench.
module cte_core_bench;
  typedef struct {logic [7:0] a; logic [4:0] f; logic [15:0] p; int len; bit bad;} cte_note_t;
  logic sys_clk, reset_n, mem_rd, mem_wr, instr_done, bad_opcode;
  logic [15:0] mem_addr, pc_out, pc, dpc;
  logic [7:0] mem_wdata, mem_rdata, acc_out, mm, sv, a, b;
  logic [4:0] flags_out, fl;
  logic [7:0] r [0:7];
  cte_note_t q[$];
  logic [23:0] wq[$];
  cte_note_t nt;
  int bad_count = 0, n_checks = 0, cyc = 0, last = 0, gap = 0;
  bit pend = 0, dbad = 0, sbad = 0;

  cte_core u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .acc_out(acc_out), .flags_out(flags_out), .pc_out(pc_out),
    .instr_done(instr_done), .bad_opcode(bad_opcode));
  cte_mem_model u_mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic final_report();
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // Bytes past the length are overwritten by the next instruction.
  task automatic emit(input int n, input logic [7:0] o, input logic [7:0] b2 = 8'h00,
                      input logic [7:0] b3 = 8'h00);
    u_mem.mem[pc] = o;
    u_mem.mem[pc + 16'h0001] = b2;
    u_mem.mem[pc + 16'h0002] = b3;
    pc = pc + 16'(n);
  endtask : emit

  task automatic note(input int len, input bit bad = 1'h0);
    q.push_back('{r[7], fl, pc, len, bad});
  endtask : note

  task automatic wnote(input logic [15:0] ad, input logic [7:0] d);
    wq.push_back({ad, d});
  endtask : wnote

  task automatic alu(input bit sb, input bit uc, input logic [7:0] v);
    logic [8:0] s;
    logic [4:0] h;
    logic c;
    c = uc & fl[0];
    if (sb) begin
      s = {1'h0, r[7]} + {1'h0, ~v} + {8'h00, ~c};
      h = {1'h0, r[7][3:0]} + {1'h0, ~v[3:0]} + {4'h0, ~c};
      s[8] = ~s[8];
    end else begin
      s = {1'h0, r[7]} + {1'h0, v} + {8'h00, c};
      h = {1'h0, r[7][3:0]} + {1'h0, v[3:0]} + {4'h0, c};
    end
    r[7] = s[7:0];
    fl = {s[7], s[7:0] == 8'h00, h[4], ~^s[7:0], s[8]};
  endtask : alu

  // Length is judged between two consecutive instruction ends.
  always @(posedge sys_clk) begin
    cyc++;
    if (pend && q.size() > 0) begin
      nt = q.pop_front();
      chk(acc_out === nt.a && flags_out === nt.f, "accumulator or flags wrong");
      chk(nt.len == 0 || gap == nt.len, "instruction length wrong");
      chk(dbad == nt.bad, "unsupported opcode report wrong");
      chk(dpc === nt.p, "program counter wrong");
    end
    pend = 1'h0;
    // The unsupported report comes one cycle ahead of the instruction end.
    if (reset_n === 1'h1 && bad_opcode === 1'h1) sbad = 1'h1;
    if (reset_n === 1'h1 && instr_done === 1'h1) begin
      gap = cyc - last;
      last = cyc;
      dbad = sbad;
      sbad = 1'h0;
      dpc = pc_out;
      pend = 1'h1;
    end
    if (reset_n === 1'h1 && mem_wr === 1'h1) begin
      if (wq.size() > 0) chk({mem_addr, mem_wdata} === wq.pop_front(), "write wrong");
      else chk(1'h0, "unexpected write");
    end
  end

  initial begin
    reset_n = 1'h0;
    pc = 16'h0000;
    fl = 5'h00;
    sv = 8'($urandom(50836));
    for (int i = 0; i < 8; i++) r[i] = 8'h00;
    for (int i = 0; i < 65536; i++) u_mem.mem[i] = 8'h00;
    emit(3, 8'h21, 8'h00, 8'h80); r[4] = 8'h80; r[5] = 8'h00; note(0);
    mm = 8'($urandom); emit(2, 8'h36, mm); wnote(16'h8000, mm); note(10);
    for (int k = 0; k < 4; k++) begin
      a = 8'($urandom); emit(2, 8'h3E, a); r[7] = a; note(7);
      emit(1, 8'h47); r[0] = r[7]; note(5);
      a = 8'($urandom); emit(2, 8'h3E, a); r[7] = a; note(7);
      emit(1, 8'h80); alu(0, 0, r[0]); note(4);
      b = 8'($urandom); emit(2, 8'hC6, b); alu(0, 0, b); note(7);
      b = 8'($urandom); emit(2, 8'hCE, b); alu(0, 1, b); note(7);
      b = 8'($urandom); emit(2, 8'hD6, b); alu(1, 0, b); note(7);
      emit(1, 8'h98); alu(1, 1, r[0]); note(4);
      emit(1, 8'h86); alu(0, 0, mm); note(7);
      a = r[7]; b = {3'h0, fl[0]}; r[7] = mm; alu(1, 0, 8'h01); mm = r[7]; r[7] = a;
      fl[0] = b[0]; emit(1, 8'h35); wnote(16'h8000, mm); note(10);
    end
    // Only the D,E pair is used for indirect access, keeping clear of other pairs.
    emit(3, 8'h11, 8'h00, 8'h90); r[2] = 8'h90; r[3] = 8'h00; note(10);
    sv = r[7]; emit(1, 8'h12); wnote(16'h9000, sv); note(7);
    emit(2, 8'h3E, ~sv); r[7] = ~sv; note(7);
    emit(1, 8'h1A); r[7] = sv; note(7);
    sv = ~sv; r[7] = sv; emit(2, 8'h3E, sv); note(7);
    emit(3, 8'h32, 8'h20, 8'hA0); wnote(16'hA020, sv); note(13);
    emit(2, 8'h3E, 8'h5A); r[7] = 8'h5A; note(7);
    emit(3, 8'h3A, 8'h20, 8'hA0); r[7] = sv; note(13);
    emit(3, 8'h21, 8'hFF, 8'h12); r[4] = 8'h12; r[5] = 8'hFF; note(10);
    emit(3, 8'h22, 8'h30, 8'hA0); wnote(16'hA030, 8'hFF); wnote(16'hA031, 8'h12);
    note(16);
    emit(1, 8'hEB); r[2] = 8'h12; r[3] = 8'hFF; r[4] = 8'h90; r[5] = 8'h00; note(4);
    emit(3, 8'h2A, 8'h30, 8'hA0); r[4] = 8'h12; r[5] = 8'hFF; note(16);
    emit(1, 8'h23); r[4] = 8'h13; r[5] = 8'h00; note(5);
    for (int i = 2; i < 6; i++) begin
      emit(1, {5'h0F, 3'(i)}); r[7] = r[i]; note(5);
    end
    emit(1, 8'h00); note(4, 1'h1);
    repeat (4) @(posedge sys_clk);
    #2 reset_n = 1'h1;
    for (int t = 0; t < 3000 && (q.size() > 0 || wq.size() > 0); t++) @(posedge sys_clk);
    if (q.size() > 0 || wq.size() > 0) chk(1'h0, "timeout");
    repeat (2) @(posedge sys_clk);
    final_report();
  end
endmodule : cte_core_bench

`default_nettype wire
